// *** src/fes_host.v ***
// Host controller sequencing erase, suspend and status polling on a flash
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "fes_map.vh"
module fes_host #(
  parameter RESUME_CYC = `FES_RESUME_CYC
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg  [11:0] flash_addr,
  output reg  [7:0]  flash_dq_out,
  output reg         flash_dq_oe,
  input  wire [7:0]  flash_dq_in,
  output reg         flash_ce_n,
  output reg         flash_we_n,
  output reg         flash_oe_n,
  input  wire        ready_busy_pin
);
  localparam S_IDLE = 6'b000001;
  localparam S_WR   = 6'b000010;
  localparam S_RD   = 6'b000100;
  localparam S_NEXT = 6'b001000;
  localparam S_POLL = 6'b010000;
  localparam S_DONE = 6'b100000;

  reg [5:0]  state_ff;
  reg [3:0]  op_ff;
  reg [2:0]  step_ff;
  reg [1:0]  ph_ff;
  reg [11:0] addr_ff;
  reg [7:0]  data_ff;
  reg [7:0]  prev_ff;
  reg        have_prev_ff;
  reg        busy_ff;
  reg        done_ff;
  reg        timeout_ff;
  reg        abort_ff;
  reg        refused_ff;
  reg        esusp_ff;
  reg        psusp_ff;
  reg        chip_busy_ff;
  reg        need_chk_ff;
  reg [7:0]  last_ff;
  reg [22:0] gap_ff;
  reg        pend_ff;
  reg [3:0]  pend_op_ff;
  reg [2:0]  nsteps;
  reg [11:0] cyc_a;
  reg [7:0]  cyc_d;
  reg        polls;
  reg        ok;
  wire [7:0] dq_s;
  wire       rb_s;

  // Pins from the flash are asynchronous to our clock
  fes_sync #(.W(9)) u_sync (
    .clock (clock),
    .rst   (rst),
    .din   ({ready_busy_pin, flash_dq_in}),
    .dout  ({rb_s, dq_s})
  );

  // Number of write cycles for each operation
  always @* begin
    polls = 1'b1;
    case (op_ff)
      `FES_OP_CHIP_ERASE, `FES_OP_SECT_ERASE: nsteps = 3'd6;
      `FES_OP_PROGRAM: nsteps = 3'd4;
      `FES_OP_ERS_SUSP, `FES_OP_PRG_SUSP, `FES_OP_RESET: begin
        nsteps = 3'd1;
        polls  = 1'b0;
      end
      `FES_OP_READ: begin
        nsteps = 3'd0;
        polls  = 1'b0;
      end
      default: nsteps = 3'd1; // Resumes and blank
    endcase
  end

  // Address and data of the current write cycle
  always @* begin
    cyc_a = `FES_UNLK_A1;
    cyc_d = `FES_UNLK_D1;
    case (step_ff)
      3'd0: begin
        if (nsteps == 3'd1) begin
          cyc_a = (op_ff == `FES_OP_BLANK) ? `FES_UNLK_A1 : addr_ff;
          case (op_ff)
            `FES_OP_ERS_SUSP: cyc_d = `FES_CMD_ESUS;
            `FES_OP_ERS_RES:  cyc_d = `FES_CMD_ERES;
            `FES_OP_PRG_SUSP: cyc_d = `FES_CMD_PSUS;
            `FES_OP_PRG_RES:  cyc_d = `FES_CMD_PRES;
            `FES_OP_BLANK:    cyc_d = `FES_CMD_BLNK;
            default:          cyc_d = `FES_CMD_RST;
          endcase
        end
      end
      3'd1, 3'd4: begin
        cyc_a = `FES_UNLK_A2;
        cyc_d = `FES_UNLK_D2;
      end
      3'd2: cyc_d = (nsteps == 3'd4) ? `FES_CMD_PROG : `FES_CMD_CFG;
      3'd3: begin
        cyc_a = addr_ff;
        cyc_d = (nsteps == 3'd4) ? data_ff : `FES_UNLK_D1;
      end
      default: begin
        cyc_a = (op_ff == `FES_OP_CHIP_ERASE) ? `FES_UNLK_A1 : addr_ff;
        cyc_d = (op_ff == `FES_OP_CHIP_ERASE) ? `FES_CMD_CHIP
                                              : `FES_CMD_SECT;
      end
    endcase
  end

  // Legality of a new order against the flash state we track
  always @* begin
    case (reg_wdata[3:0])
      `FES_OP_CHIP_ERASE, `FES_OP_SECT_ERASE:
        ok = !busy_ff && !esusp_ff && !psusp_ff && !need_chk_ff;
      `FES_OP_PROGRAM: ok = !busy_ff && !psusp_ff;
      `FES_OP_ERS_SUSP:
        ok = busy_ff && !chip_busy_ff && !esusp_ff && gap_ff == 23'd0 &&
             (op_ff == `FES_OP_SECT_ERASE || op_ff == `FES_OP_ERS_RES);
      `FES_OP_PRG_SUSP:
        ok = busy_ff && !psusp_ff && gap_ff == 23'd0 &&
             (op_ff == `FES_OP_PROGRAM || op_ff == `FES_OP_PRG_RES);
      `FES_OP_ERS_RES: ok = esusp_ff && !busy_ff;
      `FES_OP_PRG_RES: ok = psusp_ff && !busy_ff;
      `FES_OP_BLANK: ok = !busy_ff && !esusp_ff && !psusp_ff;
      `FES_OP_RESET: ok = !busy_ff || timeout_ff;
      `FES_OP_READ: ok = !busy_ff;
      default: ok = 1'b0;
    endcase
    // Only a suspend may cut into a running poll; held pending if taken in S_RD, dropped if taken in S_POLL
    if (state_ff != S_IDLE)
      ok = ok && !pend_ff && (state_ff == S_RD || state_ff == S_POLL) &&
           (reg_wdata[3:0] == `FES_OP_ERS_SUSP ||
            reg_wdata[3:0] == `FES_OP_PRG_SUSP);
  end

  // Sequencer and register file
  always @(posedge clock) begin
    if (rst) begin
      state_ff <= S_IDLE;
      op_ff <= 4'h0;
      step_ff <= 3'd0;
      ph_ff <= 2'd0;
      addr_ff <= 12'h000;
      data_ff <= 8'h00;
      prev_ff <= 8'h00;
      have_prev_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      timeout_ff <= 1'b0;
      abort_ff <= 1'b0;
      refused_ff <= 1'b0;
      esusp_ff <= 1'b0;
      psusp_ff <= 1'b0;
      chip_busy_ff <= 1'b0;
      need_chk_ff <= 1'b0;
      last_ff <= 8'h00;
      gap_ff <= 23'd0;
      pend_ff <= 1'b0;
      pend_op_ff <= 4'h0;
      reg_rdata <= 32'h0000_0000;
      flash_addr <= 12'h000;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      if (gap_ff != 23'd0)
        gap_ff <= gap_ff - 23'd1;
      // Register reads, data one cycle later
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `FES_REG_ADDR: reg_rdata <= {20'h00000, addr_ff};
          `FES_REG_DATA: reg_rdata <= {24'h000000, data_ff};
          `FES_REG_STATUS: reg_rdata <= {22'h000000, need_chk_ff,
            psusp_ff, esusp_ff, refused_ff, abort_ff, timeout_ff,
            done_ff, busy_ff, state_ff == S_IDLE, 1'b0};
          `FES_REG_RESULT: reg_rdata <= {24'h000000, last_ff};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
      if (reg_wr && reg_addr == `FES_REG_ADDR)
        addr_ff <= reg_wdata[11:0];
      if (reg_wr && reg_addr == `FES_REG_DATA)
        data_ff <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `FES_REG_CTRL) begin
        refused_ff <= !ok;
        if (ok && state_ff != S_IDLE) begin
          pend_ff <= 1'b1;
          pend_op_ff <= reg_wdata[3:0];
        end
        if (ok && state_ff == S_IDLE) begin
          op_ff <= reg_wdata[3:0];
          step_ff <= 3'd0;
          ph_ff <= 2'd0;
          done_ff <= 1'b0;
          state_ff <= (reg_wdata[3:0] == `FES_OP_READ) ? S_RD : S_WR;
        end
      end
      // Software clear first, so an abort seen in the same cycle wins
      if (reg_wr && reg_addr == `FES_REG_STATUS && reg_wdata[5])
        abort_ff <= 1'b0;
      case (state_ff)
        S_IDLE: ;
        // Write cycle: drive address/data, pulse we_n low for one clock of three
        S_WR: begin
          flash_addr <= cyc_a;
          flash_dq_out <= cyc_d;
          flash_dq_oe <= 1'b1;
          flash_oe_n <= 1'b1;
          flash_ce_n <= 1'b0;
          ph_ff <= ph_ff + 2'd1;
          flash_we_n <= (ph_ff == 2'd0) ? 1'b0 : 1'b1;
          if (ph_ff == 2'd2) begin
            ph_ff <= 2'd0;
            flash_ce_n <= 1'b1;
            if (step_ff + 3'd1 >= nsteps) begin
              state_ff <= S_NEXT;
            end else begin
              step_ff <= step_ff + 3'd1;
            end
          end
        end
        // Command issued: update tracked flash state
        S_NEXT: begin
          flash_dq_oe <= 1'b0;
          have_prev_ff <= 1'b0;
          state_ff <= polls ? S_RD : S_DONE;
          case (op_ff)
            `FES_OP_CHIP_ERASE: begin
              busy_ff <= 1'b1; // no order but a reset after a time-out accepted until done
              chip_busy_ff <= 1'b1;
            end
            `FES_OP_SECT_ERASE, `FES_OP_PROGRAM, `FES_OP_BLANK:
              busy_ff <= 1'b1;
            `FES_OP_ERS_SUSP, `FES_OP_PRG_SUSP: state_ff <= S_RD;
            `FES_OP_ERS_RES: begin
              esusp_ff <= 1'b0;
              busy_ff <= 1'b1;
              gap_ff <= RESUME_CYC[22:0];
            end
            `FES_OP_PRG_RES: begin
              psusp_ff <= 1'b0;
              busy_ff <= 1'b1;
              gap_ff <= RESUME_CYC[22:0];
            end
            `FES_OP_RESET: begin
              busy_ff <= 1'b0;
              timeout_ff <= 1'b0;
              chip_busy_ff <= 1'b0;
            end
            default: ;
          endcase
        end
        // Status read at the operation address, or at FES_UNLK_A1 for chip erase and blank check
        S_RD: begin
          flash_addr <= (op_ff == `FES_OP_BLANK || op_ff == `FES_OP_CHIP_ERASE)
                        ? `FES_UNLK_A1 : addr_ff;
          flash_dq_oe <= 1'b0;
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b0;
          ph_ff <= ph_ff + 2'd1;
          if (ph_ff == 2'd3) begin
            ph_ff <= 2'd0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            state_ff <= (op_ff == `FES_OP_READ) ? S_DONE : S_POLL;
          end
        end
        // Toggle check: two reads that match mean finished
        S_POLL: begin
          prev_ff <= dq_s;
          have_prev_ff <= 1'b1;
          last_ff <= dq_s;
          state_ff <= S_RD;
          pend_ff <= 1'b0;
          // Pin must show ready too, so a stalled toggle is not taken as done
          if (have_prev_ff && rb_s &&
              prev_ff[`FES_BIT_TGL] == dq_s[`FES_BIT_TGL]) begin
            state_ff <= S_DONE;
            need_chk_ff <= 1'b0;
            busy_ff <= 1'b0;
            chip_busy_ff <= 1'b0;
            if (op_ff == `FES_OP_ERS_SUSP) begin
              esusp_ff <= 1'b1;
              need_chk_ff <= 1'b1;
            end
            if (op_ff == `FES_OP_PRG_SUSP) begin
              psusp_ff <= 1'b1;
              need_chk_ff <= 1'b1;
            end
          end else if (have_prev_ff && dq_s[`FES_BIT_TLF] &&
                       prev_ff[`FES_BIT_TLF]) begin
            // Flag seen twice with toggling still: failed, reset needed
            timeout_ff <= 1'b1;
            state_ff <= S_DONE;
          end else if (pend_ff) begin
            // Still running: now send the suspend that was ordered
            op_ff <= pend_op_ff;
            step_ff <= 3'd0;
            ph_ff <= 2'd0;
            state_ff <= S_WR;
          end
          if (dq_s[`FES_BIT_BAF] && op_ff == `FES_OP_PROGRAM) begin
            abort_ff <= 1'b1;
            busy_ff <= 1'b0;
            state_ff <= S_DONE;
          end
        end
        S_DONE: begin
          done_ff <= 1'b1;
          state_ff <= S_IDLE;
          if (op_ff == `FES_OP_READ)
            last_ff <= dq_s;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // fes_host

// *** src/fes_map.vh ***
// Constants and command codes for the flash erase/suspend/status host
`ifndef FES_MAP_VH
`define FES_MAP_VH
// Software register offsets
`define FES_REG_CTRL    4'h0
`define FES_REG_ADDR    4'h1
`define FES_REG_DATA    4'h2
`define FES_REG_STATUS  4'h3
`define FES_REG_RESULT  4'h4
// Operation codes written to CTRL[3:0]
`define FES_OP_CHIP_ERASE  4'h1
`define FES_OP_SECT_ERASE  4'h2
`define FES_OP_PROGRAM     4'h3
`define FES_OP_ERS_SUSP    4'h4
`define FES_OP_ERS_RES     4'h5
`define FES_OP_PRG_SUSP    4'h6
`define FES_OP_PRG_RES     4'h7
`define FES_OP_BLANK       4'h8
`define FES_OP_RESET       4'h9
`define FES_OP_READ        4'hA
// Flash command cycle values
`define FES_UNLK_A1  12'h555
`define FES_UNLK_A2  12'h2AA
`define FES_UNLK_D1  8'hAA
`define FES_UNLK_D2  8'h55
`define FES_CMD_CFG  8'h80
`define FES_CMD_CHIP 8'h10
`define FES_CMD_SECT 8'h30
`define FES_CMD_PROG 8'hA0
`define FES_CMD_ESUS 8'hB0
`define FES_CMD_ERES 8'h30
`define FES_CMD_PSUS 8'h51
`define FES_CMD_PRES 8'h50
`define FES_CMD_BLNK 8'h33
`define FES_CMD_RST  8'hF0
// Status bit positions
`define FES_BIT_DCB   7
`define FES_BIT_TGL   6
`define FES_BIT_TLF   5
`define FES_BIT_BAF   1
// Timing: bus cycle phase length and resume-to-suspend gap
`define FES_CLK_NS        40
`define FES_PH_NS         80
`define FES_PH_CYC        ((`FES_PH_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_RESUME_NS     100000
`define FES_RESUME_CYC    ((`FES_RESUME_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`endif

// *** src/fes_sync.v ***
// Two-stage synchroniser for flash pins entering the clock domain
`timescale 1ns/1ps
module fes_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always @(posedge clock) begin
    if (rst) begin
      meta_ff <= {W{1'b0}};
      dout    <= {W{1'b0}};
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule // fes_sync

// *** tb/fes_flash_model.sv ***
// Behavioural flash device answering the host's command cycles
`timescale 1ns/1ps
module fes_flash_model #(
  parameter ERS_NS = 20000,
  parameter PRG_NS = 8000,
  parameter SUS_NS = 400
) (
  input  wire [11:0] flash_addr,
  input  wire [7:0]  flash_dq_out,
  input  wire        flash_ce_n,
  input  wire        flash_we_n,
  input  wire        flash_oe_n,
  output reg  [7:0]  flash_dq_in,
  output wire        ready_busy_pin
);
  reg [7:0]  mem [0:4095];
  reg [11:0] pa;
  reg [7:0]  pd, d;
  reg [3:0]  es;
  reg [2:0]  cyc, kind;
  reg        busy, tgl, tlf, esus, psus, fail_next;
  integer    wr_cnt, blank_cnt, rem, sv_rem, lat, i;
  // Open drain with pull-up: high whenever released
  assign ready_busy_pin = busy ? 1'b0 : 1'b1;
  initial begin
    for (i = 0; i < 4096; i = i + 1) mem[i] = 8'h00;
    {busy, tgl, tlf, esus, psus, fail_next, cyc, kind} = 0;
    {wr_cnt, blank_cnt, rem, sv_rem, lat} = 0;
    flash_dq_in = 8'h00;
  end
  // Nested program keeps the suspended erase's remaining time
  task start(input [2:0] k, input integer t);
    sv_rem = rem;
    kind = k;
    rem = t;
    busy = 1'b1;
  endtask
  task finish_op;
    if (fail_next) begin
      tlf = 1'b1; // Stays busy until a reset
      fail_next = 1'b0;
    end else begin
      busy = 1'b0; // Back to array read unaided
      if (kind == 3'd1) for (i = 0; i < 4096; i = i + 1) mem[i] = 8'hFF;
      if (kind == 3'd2) for (i = 0; i < 256; i = i + 1) mem[{es, i[7:0]}] = 8'hFF;
      if (kind == 3'd3) mem[pa] = mem[pa] & pd;
      kind = esus ? 3'd2 : 3'd0;
      rem = sv_rem;
    end
  endtask
  // Command cycles are taken on the rising write strobe
  always @(posedge flash_we_n) if (!flash_ce_n && flash_oe_n) begin
    wr_cnt = wr_cnt + 1;
    d = flash_dq_out;
    if (busy) begin // Only suspends, or a reset after a time-out, count while busy
      if (tlf && d == 8'hF0) {busy, tlf, kind} = 0;
      else if (!tlf && kind == 3'd2 && d == 8'hB0) lat = SUS_NS;
      else if (!tlf && kind == 3'd3 && d == 8'h51) lat = SUS_NS;
    end else if (cyc == 3'd6) begin
      pa = flash_addr;
      pd = d;
      cyc = 3'd0;
      start(3'd3, PRG_NS);
    end else if (cyc == 3'd0 && d == 8'h30 && esus) begin
      esus = 1'b0;
      busy = 1'b1;
    end else if (cyc == 3'd0 && d == 8'h50 && psus) begin
      psus = 1'b0;
      busy = 1'b1;
    end else if (cyc == 3'd0 && d == 8'h33 && !esus && !psus) begin
      blank_cnt = blank_cnt + 1; // Idle only
      start(3'd4, PRG_NS);
    end else case (cyc)
      3'd0: cyc = (d == 8'hAA) ? 3'd1 : 3'd0;
      3'd1: cyc = (d == 8'h55) ? 3'd2 : 3'd0;
      3'd2: cyc = (d == 8'h80) ? 3'd3 : (d == 8'hA0 && !psus) ? 3'd6 : 3'd0;
      3'd3: cyc = (d == 8'hAA) ? 3'd4 : 3'd0;
      3'd4: cyc = (d == 8'h55) ? 3'd5 : 3'd0;
      default: begin // Erases refused while suspended
        cyc = 3'd0;
        es = flash_addr[11:8];
        if (!esus && !psus && d == 8'h10) start(3'd1, ERS_NS);
        if (!esus && !psus && d == 8'h30) start(3'd2, ERS_NS);
      end
    endcase
  end
  // Time base of the embedded algorithms and suspend latency
  always #40 begin
    if (lat > 0) begin
      lat = lat - 40;
      if (lat <= 0) begin
        busy = 1'b0;
        esus = esus | (kind == 3'd2);
        psus = kind == 3'd3;
      end
    end else if (busy && !tlf && rem > 0) begin
      rem = rem - 40;
      if (rem <= 0) finish_op;
    end
  end
  // Status replaces array data while busy or in the suspended sector
  always @(negedge flash_oe_n) if (!flash_ce_n) begin
    if (busy) begin
      tgl = ~tgl; // Flips on every status read
      flash_dq_in = {kind == 3'd3 ? ~pd[7] : 1'b0, tgl, tlf, 5'h00};
    end else if (esus && flash_addr[11:8] == es) begin
      flash_dq_in = 8'h80; // No toggle in suspended sector
    end else begin
      flash_dq_in = mem[flash_addr]; // True data when done
    end
  end
  // Released bus shows the inverse of its last value
  always @(posedge flash_oe_n) flash_dq_in = ~flash_dq_in;
endmodule // fes_flash_model

// *** tb/fes_host_sva.sv ***
// Checker of the host's flash bus cycles and command order
`timescale 1ns/1ps
module fes_host_sva #(
  parameter RESUME_CYC = 4
) (
  input wire        clock,
  input wire        rst,
  input wire [11:0] flash_addr,
  input wire [7:0]  flash_dq_out,
  input wire        flash_dq_oe,
  input wire        flash_ce_n,
  input wire        flash_we_n,
  input wire        flash_oe_n
);
  reg [39:0] hist_ff;
  reg [15:0] gap_ff;
  // Last five command bytes; cycles since a resume byte
  always @(posedge clock) begin
    if (rst) begin
      hist_ff <= 40'h0;
      gap_ff  <= 16'hFFFF;
    end else if ($fell(flash_we_n)) begin
      hist_ff <= {hist_ff[31:0], flash_dq_out};
      if (flash_dq_out == 8'h30 || flash_dq_out == 8'h50) gap_ff <= 16'h0;
    end else if (gap_ff != 16'hFFFF) begin
      gap_ff <= gap_ff + 16'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wr;
    $fell(flash_we_n);
  endsequence
  sequence s_rd_hold;
    !flash_oe_n [*3] ##1 flash_oe_n;
  endsequence
  AST_WR_PULSE: assert property (s_wr |=> flash_we_n [*2])
    else $error("write strobe not one low clock in three");
  AST_WR_QUAL: assert property (!flash_we_n |->
    !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe without select or drive");
  AST_WR_HOLD: assert property (s_wr |=>
    $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in write cycle");
  AST_CHIP_SEQ: assert property (
    (s_wr and (flash_dq_out == 8'h10)) |->
    hist_ff == 40'hAA5580AA55 && flash_addr == 12'h555)
    else $error("chip erase byte without its five lead cycles");
  AST_BLANK_ADDR: assert property (
    (s_wr and (flash_dq_out == 8'h33)) |->
    flash_addr[10:0] == 11'h555)
    else $error("blank check byte at wrong address");
  AST_RD_LEN: assert property ($fell(flash_oe_n) |-> s_rd_hold)
    else $error("read strobe not three clocks long");
  AST_RD_QUAL: assert property (!flash_oe_n |->
    !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("read strobe with bus contention");
  AST_ESUS_GAP: assert property (
    (s_wr and (flash_dq_out == 8'hB0)) |->
    gap_ff >= RESUME_CYC)
    else $error("erase suspend too soon after resume");
  AST_PSUS_GAP: assert property (
    (s_wr and (flash_dq_out == 8'h51)) |->
    gap_ff >= RESUME_CYC)
    else $error("program suspend too soon after resume");
endmodule // fes_host_sva
bind fes_host fes_host_sva #(.RESUME_CYC(RESUME_CYC)) u_sva (
  .clock, .rst, .flash_addr, .flash_dq_out, .flash_dq_oe,
  .flash_ce_n, .flash_we_n, .flash_oe_n);

// *** tb/tb_fes_host.sv ***
// Self-checking bench for the flash erase, suspend and status host
`timescale 1ns/1ps
`include "fes_map.vh"
`define CHK(g, e) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_fes_host;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  wire [31:0] reg_rdata;
  wire [11:0] flash_addr;
  wire [7:0]  flash_dq_out, flash_dq_in;
  wire        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  wire        ready_busy_pin;
  integer     err_total = 0, cmp_count = 0, n;
  reg  [31:0] st;
  always #20 clock = ~clock;
  fes_host #(.RESUME_CYC(4)) dut (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .ready_busy_pin);
  fes_flash_model fm (
    .flash_addr, .flash_dq_out, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .flash_dq_in, .ready_busy_pin);
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wr(input [3:0] a, input [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [3:0] a, output [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task wait_bit(input integer b, input v);
    integer k;
    for (k = 0; k < 3000; k = k + 1) begin
      rd(`FES_REG_STATUS, st);
      if (st[b] === v) k = 9999;
    end
    if (k == 3000) begin
      err_total = err_total + 1;
      $display("BAD t=%0t got %h exp %h", $time, st[b], v);
      conclude;
    end
  endtask
  task rd_flash(input [11:0] a);
    wr(`FES_REG_ADDR, {20'h0, a});
    wr(`FES_REG_CTRL, `FES_OP_READ);
    wait_bit(3, 1'b1);
    rd(`FES_REG_RESULT, st);
  endtask
  task t_chip;
    n = fm.wr_cnt;
    wr(`FES_REG_CTRL, `FES_OP_CHIP_ERASE);
    wait_bit(3, 1'b1);
    `CHK(fm.wr_cnt - n, 6)
    rd_flash(12'h2C4);
    `CHK(st[7:0], 8'hFF)
    $display("end chip erase");
  endtask
  task t_prog;
    wr(`FES_REG_ADDR, 32'h210);
    wr(`FES_REG_DATA, 32'h5A);
    wr(`FES_REG_CTRL, `FES_OP_PROGRAM);
    wait_bit(2, 1'b1);
    wr(`FES_REG_CTRL, `FES_OP_PRG_SUSP);
    wait_bit(8, 1'b1);
    `CHK(fm.psus, 1'b1)
    n = fm.wr_cnt;
    wr(`FES_REG_CTRL, `FES_OP_PROGRAM);
    wr(`FES_REG_CTRL, `FES_OP_ERS_RES);
    repeat (12) @(posedge clock);
    `CHK(fm.wr_cnt - n, 0)
    wr(`FES_REG_CTRL, `FES_OP_PRG_RES);
    wait_bit(3, 1'b1);
    `CHK(st[8], 1'b0)
    rd_flash(12'h210);
    `CHK(st[7:0], 8'h5A)
    $display("end program suspend");
  endtask
  task t_erase;
    fm.mem[12'h301] = 8'h00;
    wr(`FES_REG_ADDR, 32'h300);
    wr(`FES_REG_CTRL, `FES_OP_SECT_ERASE);
    wait_bit(2, 1'b1);
    wr(`FES_REG_CTRL, `FES_OP_ERS_SUSP);
    wait_bit(7, 1'b1);
    `CHK(fm.esus, 1'b1)
    n = fm.wr_cnt;
    wr(`FES_REG_CTRL, `FES_OP_CHIP_ERASE);
    wr(`FES_REG_CTRL, `FES_OP_BLANK);
    wr(`FES_REG_CTRL, `FES_OP_PRG_RES);
    repeat (12) @(posedge clock);
    `CHK(fm.wr_cnt - n, 0)
    rd_flash(12'h310);
    `CHK(st[7:0], 8'h80)
    wr(`FES_REG_ADDR, 32'h45);
    wr(`FES_REG_DATA, 32'h3C);
    wr(`FES_REG_CTRL, `FES_OP_PROGRAM);
    wait_bit(3, 1'b1);
    `CHK(fm.mem[12'h045], 8'h3C)
    wr(`FES_REG_CTRL, `FES_OP_ERS_RES);
    wait_bit(3, 1'b1);
    `CHK(st[7], 1'b0)
    `CHK(fm.mem[12'h301], 8'hFF)
    $display("end erase suspend");
  endtask
  task t_blank;
    wr(`FES_REG_ADDR, 32'h555);
    wr(`FES_REG_CTRL, `FES_OP_BLANK);
    wait_bit(3, 1'b1);
    `CHK(fm.blank_cnt, 1)
    $display("end blank check");
  endtask
  task t_tlimit;
    fm.fail_next = 1'b1;
    wr(`FES_REG_ADDR, 32'h400);
    wr(`FES_REG_DATA, 32'h77);
    wr(`FES_REG_CTRL, `FES_OP_PROGRAM);
    wait_bit(4, 1'b1);
    `CHK(ready_busy_pin, 1'b0)
    wr(`FES_REG_CTRL, `FES_OP_RESET);
    wait_bit(1, 1'b1);
    `CHK(fm.busy, 1'b0)
    $display("end time limit");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(4'hF, st);
    rd(`FES_REG_STATUS, st);
    `CHK(st, 32'h0000_0002)
    t_chip;
    t_prog;
    t_erase;
    t_blank;
    t_tlimit;
    conclude;
  end
endmodule // tb_fes_host
